// ===== core/vec_pkg.sv
package vec_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes, reset values and timing
    localparam int WORD_W = 64;
    localparam int NUM_VREG = 8;
    localparam int MAX_VL = 64;
    localparam int REG_W = 3;
    localparam int IDX_W = 6;
    localparam int CNT_W = 7;
    localparam int UNIT_LATENCY = 5;
    localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0000;
    localparam logic [6:0] COUNT_RESET = 7'h40;
    localparam logic [6:0] COUNT_MAX = 7'h40;

    ////////////////////////////////////////////////////////////////////////////
    // Operations and element tests
    typedef enum logic [3:0] {
        OP_ADD, OP_AND, OP_SHIFT, OP_MERGE, OP_TEST, OP_CIDX,
        OP_LOAD, OP_STORE, OP_GATHER, OP_SCATTER, OP_SET_COUNT, OP_SET_MASK
    } op_e;

    typedef enum logic [1:0] {COND_ZERO, COND_NONZERO, COND_POS, COND_NEG} cond_e;

    // One issued instruction
    typedef struct packed {
        op_e op;
        cond_e cond;
        logic [REG_W-1:0] dst;
        logic [REG_W-1:0] src_a;
        logic [REG_W-1:0] src_b;
        logic use_scalar;
        logic [WORD_W-1:0] scalar;
        logic [WORD_W-1:0] base;
        logic [WORD_W-1:0] stride;
    } cmd_s;

    // One element travelling through a segmented unit
    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [WORD_W-1:0] data;
        logic flag;
    } result_s;

    // One word request towards memory
    typedef struct packed {
        logic write;
        logic [WORD_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mem_req_s;

    ////////////////////////////////////////////////////////////////////////////
    // Shared functions
    function automatic logic cond_true(input cond_e c, input logic [WORD_W-1:0] v);
        case (c)
            COND_ZERO: cond_true = (v == '0);
            COND_NONZERO: cond_true = (v != '0);
            COND_POS: cond_true = !v[WORD_W-1];
            default: cond_true = v[WORD_W-1];
        endcase
    endfunction

    // Element 0 sits in the top bit of the mask
    function automatic logic [IDX_W-1:0] mask_pos(input logic [IDX_W-1:0] i);
        mask_pos = ~i;
    endfunction

    function automatic logic [WORD_W-1:0] alu(input op_e op, input logic [WORD_W-1:0] a,
                                              input logic [WORD_W-1:0] b, input logic m);
        case (op)
            OP_ADD: alu = a + b;
            OP_AND: alu = a & b;
            OP_SHIFT: alu = a << b[5:0];
            OP_MERGE: alu = m ? a : b;
            default: alu = a;
        endcase
    endfunction

    function automatic logic is_mem(input op_e op);
        is_mem = (op == OP_LOAD) || (op == OP_STORE) || (op == OP_GATHER) || (op == OP_SCATTER);
    endfunction

endpackage

// ===== core/seg_pipe.sv
`timescale 1ns/100ps
// Segmented unit: one element enters and one leaves per cycle
module seg_pipe #(
    parameter int LATENCY = vec_pkg::UNIT_LATENCY
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire vec_pkg::result_s in_data,
    output logic out_valid,
    output vec_pkg::result_s out_data
);

    vec_pkg::result_s stage_data_reg [LATENCY];
    logic [LATENCY-1:0] stage_valid_reg;

    initial begin
        if (LATENCY < 1) begin
            $error("seg_pipe needs at least one segment");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every segment hands on its partial result each cycle, so no stall
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage_valid_reg <= '0;
            for (int s = 0; s < LATENCY; s++) begin
                stage_data_reg[s] <= '0;
            end
        end else begin
            stage_valid_reg[0] <= in_valid;
            stage_data_reg[0] <= in_data;
            for (int s = 1; s < LATENCY; s++) begin
                stage_valid_reg[s] <= stage_valid_reg[s-1];
                stage_data_reg[s] <= stage_data_reg[s-1];
            end
        end
    end

    assign out_valid = stage_valid_reg[LATENCY-1];
    assign out_data = stage_data_reg[LATENCY-1];

endmodule // seg_pipe

// ===== core/vec_chain_unit.sv
`timescale 1ns/100ps
module vec_chain_unit #(
    parameter int NUM_VREG = vec_pkg::NUM_VREG,
    parameter int MAX_VL = vec_pkg::MAX_VL,
    parameter int LATENCY = vec_pkg::UNIT_LATENCY
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic issue_valid,
    input wire vec_pkg::cmd_s issue_cmd,
    output logic arith_busy,
    output logic mem_busy,
    output logic mem_req_valid,
    output vec_pkg::mem_req_s mem_req,
    input wire logic mem_req_ready,
    input wire logic mem_rsp_valid,
    input wire logic [vec_pkg::WORD_W-1:0] mem_rsp_data,
    output logic [vec_pkg::MAX_VL-1:0] element_mask,
    output logic [vec_pkg::CNT_W-1:0] element_count,
    input wire logic [vec_pkg::REG_W-1:0] read_reg,
    input wire logic [vec_pkg::IDX_W-1:0] read_idx,
    output logic [vec_pkg::WORD_W-1:0] read_data
);

    localparam int W = vec_pkg::WORD_W;
    localparam int IW = vec_pkg::IDX_W;
    localparam int CW = vec_pkg::CNT_W;
    localparam int RW = vec_pkg::REG_W;

    // The mask has one bit per element and index fields are fixed width
    initial begin
        if (MAX_VL != vec_pkg::MAX_VL || NUM_VREG != (1 << RW) || LATENCY < 1) begin
            $error("vec_chain_unit parameters do not fit the element files");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage: element files and per-element written flags
    logic [W-1:0] elem_file [NUM_VREG][MAX_VL];
    logic [MAX_VL-1:0] elem_valid [NUM_VREG];

    // Arithmetic slot state
    vec_pkg::op_e a_op_reg;
    vec_pkg::cond_e a_cond_reg;
    logic [RW-1:0] a_dst_reg, a_src_a_reg, a_src_b_reg;
    logic a_scal_reg;
    logic [W-1:0] scalar_reg;
    logic [CW-1:0] a_idx_reg, a_wptr_reg;
    logic [CW-1:0] a_pend_reg;

    // Memory slot state
    vec_pkg::op_e m_op_reg;
    logic [RW-1:0] m_dst_reg, m_src_a_reg, m_src_b_reg;
    logic [W-1:0] base_addr_reg, m_stride_reg, m_addr_reg;
    logic [CW-1:0] m_req_cnt_reg, m_rsp_cnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Issue decode
    logic arith_op, mem_op, ctrl_op, arith_take, mem_take, ctrl_take, writes_dst;
    assign arith_op = !vec_pkg::is_mem(issue_cmd.op) && issue_cmd.op != vec_pkg::OP_SET_COUNT
        && issue_cmd.op != vec_pkg::OP_SET_MASK;
    assign mem_op = vec_pkg::is_mem(issue_cmd.op);
    assign ctrl_op = !arith_op && !mem_op;
    // A slot may not claim a destination the other slot is still filling
    assign arith_take = issue_valid && arith_op && !arith_busy && !(mem_busy && issue_cmd.dst == m_dst_reg);
    assign mem_take = issue_valid && mem_op && !mem_busy && !(arith_busy && issue_cmd.dst == a_dst_reg);
    assign ctrl_take = issue_valid && ctrl_op && !arith_busy && !mem_busy;
    assign writes_dst = (arith_take && issue_cmd.op != vec_pkg::OP_TEST)
        || (mem_take && (issue_cmd.op == vec_pkg::OP_LOAD || issue_cmd.op == vec_pkg::OP_GATHER));

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic streaming: an element enters once its sources are written
    logic a_single, a_src_ok, a_step, a_done;
    logic [IW-1:0] a_pos;
    logic [W-1:0] a_opnd, b_opnd;
    vec_pkg::result_s pipe_in, pipe_out;
    logic pipe_out_valid;

    assign a_pos = a_idx_reg[IW-1:0];
    assign a_single = (a_op_reg == vec_pkg::OP_TEST) || (a_op_reg == vec_pkg::OP_CIDX);
    // Reading a file that is still a destination is allowed element by element
    assign a_src_ok = elem_valid[a_src_a_reg][a_pos]
        && (a_single || a_scal_reg || elem_valid[a_src_b_reg][a_pos]);
    assign a_step = arith_busy && (a_idx_reg < element_count) && a_src_ok;
    assign a_opnd = elem_file[a_src_a_reg][a_pos];
    assign b_opnd = a_scal_reg ? scalar_reg : elem_file[a_src_b_reg][a_pos];
    assign a_done = arith_busy && (a_idx_reg == element_count) && (a_pend_reg == '0);

    // Operand pair and mask bit combine before the segments
    always_comb begin
        pipe_in.idx = a_pos;
        pipe_in.data = vec_pkg::alu(a_op_reg, a_opnd, b_opnd,
            element_mask[vec_pkg::mask_pos(a_pos)]);
        pipe_in.flag = vec_pkg::cond_true(a_cond_reg, a_opnd);
    end

    seg_pipe #(
        .LATENCY(LATENCY)
    ) unit_pipe (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(a_step),
        .in_data(pipe_in),
        .out_valid(pipe_out_valid),
        .out_data(pipe_out)
    );

    logic wb_cidx, wb_test, wb_write;
    assign wb_cidx = pipe_out_valid && a_op_reg == vec_pkg::OP_CIDX;
    assign wb_test = pipe_out_valid && a_op_reg == vec_pkg::OP_TEST;
    assign wb_write = pipe_out_valid && !wb_test && (!wb_cidx || pipe_out.flag);

    ////////////////////////////////////////////////////////////////////////////
    // Memory path: requests as a unit stream, loads land as they return
    logic m_is_load, m_is_index, m_data_ok, m_send, m_done, m_rsp_take;
    logic [IW-1:0] m_pos;
    logic [W-1:0] m_target;
    assign m_pos = m_req_cnt_reg[IW-1:0];
    assign m_is_load = (m_op_reg == vec_pkg::OP_LOAD) || (m_op_reg == vec_pkg::OP_GATHER);
    assign m_is_index = (m_op_reg == vec_pkg::OP_GATHER) || (m_op_reg == vec_pkg::OP_SCATTER);
    // Stores wait for chained data, indexed access waits for its index
    assign m_data_ok = (m_is_load || elem_valid[m_src_a_reg][m_pos])
        && (!m_is_index || elem_valid[m_src_b_reg][m_pos]);
    assign m_send = mem_busy && (m_req_cnt_reg < element_count) && m_data_ok
        && (!mem_req_valid || mem_req_ready);
    assign m_target = m_is_index ? base_addr_reg + elem_file[m_src_b_reg][m_pos] : m_addr_reg;
    assign m_rsp_take = mem_busy && m_is_load && mem_rsp_valid && (m_rsp_cnt_reg < element_count);
    assign m_done = mem_busy && (m_req_cnt_reg == element_count)
        && (m_is_load ? (m_rsp_cnt_reg == element_count) : (!mem_req_valid || mem_req_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic slot control
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            arith_busy <= 1'b0;
            a_op_reg <= vec_pkg::OP_ADD;
            a_cond_reg <= vec_pkg::COND_ZERO;
            a_dst_reg <= '0;
            a_src_a_reg <= '0;
            a_src_b_reg <= '0;
            a_scal_reg <= 1'b0;
            scalar_reg <= '0;
            a_idx_reg <= '0;
            a_wptr_reg <= '0;
            a_pend_reg <= '0;
        end else begin
            if (arith_take) begin
                arith_busy <= 1'b1;
                a_op_reg <= issue_cmd.op;
                a_cond_reg <= issue_cmd.cond;
                a_dst_reg <= issue_cmd.dst;
                a_src_a_reg <= issue_cmd.src_a;
                a_src_b_reg <= issue_cmd.src_b;
                a_scal_reg <= issue_cmd.use_scalar;
                scalar_reg <= issue_cmd.scalar;
                a_idx_reg <= '0;
                a_wptr_reg <= '0;
                a_pend_reg <= '0;
            end else begin
                if (a_done) begin
                    arith_busy <= 1'b0;
                end
                if (a_step) begin
                    a_idx_reg <= a_idx_reg + 1'b1;
                end
                // Elements inside the segments, so completion waits for the last
                a_pend_reg <= a_pend_reg + CW'(a_step) - CW'(pipe_out_valid);
                if (wb_cidx && pipe_out.flag) begin
                    a_wptr_reg <= a_wptr_reg + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory slot control and request register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_busy <= 1'b0;
            m_op_reg <= vec_pkg::OP_LOAD;
            m_dst_reg <= '0;
            m_src_a_reg <= '0;
            m_src_b_reg <= '0;
            base_addr_reg <= '0;
            m_stride_reg <= '0;
            m_addr_reg <= '0;
            m_req_cnt_reg <= '0;
            m_rsp_cnt_reg <= '0;
            mem_req_valid <= 1'b0;
            mem_req <= '0;
        end else begin
            if (mem_take) begin
                mem_busy <= 1'b1;
                m_op_reg <= issue_cmd.op;
                m_dst_reg <= issue_cmd.dst;
                m_src_a_reg <= issue_cmd.src_a;
                m_src_b_reg <= issue_cmd.src_b;
                base_addr_reg <= issue_cmd.base;
                m_stride_reg <= issue_cmd.stride;
                m_addr_reg <= issue_cmd.base;
                m_req_cnt_reg <= '0;
                m_rsp_cnt_reg <= '0;
            end else if (m_done) begin
                mem_busy <= 1'b0;
            end
            if (m_send) begin
                mem_req_valid <= 1'b1;
                mem_req.write <= !m_is_load;
                mem_req.addr <= m_target;
                mem_req.wdata <= elem_file[m_src_a_reg][m_pos];
                m_req_cnt_reg <= m_req_cnt_reg + 1'b1;
                m_addr_reg <= m_addr_reg + m_stride_reg;
            end else if (mem_req_ready) begin
                mem_req_valid <= 1'b0;
            end
            if (m_rsp_take) begin
                m_rsp_cnt_reg <= m_rsp_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Element file data: two write ports, never the same file
    always_ff @(posedge ref_clk) begin
        if (wb_write) begin
            elem_file[a_dst_reg][wb_cidx ? a_wptr_reg[IW-1:0] : pipe_out.idx] <=
                wb_cidx ? W'(pipe_out.idx) : pipe_out.data;
        end
        if (m_rsp_take) begin
            elem_file[m_dst_reg][m_rsp_cnt_reg[IW-1:0]] <= mem_rsp_data;
        end
    end

    // Written flags: cleared when a file is reserved, set element by element
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int r = 0; r < NUM_VREG; r++) begin
                elem_valid[r] <= '1;
            end
        end else begin
            if (writes_dst) begin
                elem_valid[issue_cmd.dst] <= '0;
            end
            if (wb_write) begin
                elem_valid[a_dst_reg][wb_cidx ? a_wptr_reg[IW-1:0] : pipe_out.idx] <= 1'b1;
            end
            if (m_rsp_take) begin
                elem_valid[m_dst_reg][m_rsp_cnt_reg[IW-1:0]] <= 1'b1;
            end
            // Short or compressed results must not leave a consumer waiting
            if (a_done && a_op_reg != vec_pkg::OP_TEST) begin
                elem_valid[a_dst_reg] <= '1;
            end
            if (m_done && m_is_load) begin
                elem_valid[m_dst_reg] <= '1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mask register: direct load, or built by test and compressed index
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            element_mask <= vec_pkg::MASK_RESET;
        end else if (ctrl_take && issue_cmd.op == vec_pkg::OP_SET_MASK) begin
            element_mask <= issue_cmd.scalar;
        end else if (arith_take && (issue_cmd.op == vec_pkg::OP_TEST || issue_cmd.op == vec_pkg::OP_CIDX)) begin
            element_mask <= '0;
        end else if (wb_test || wb_cidx) begin
            element_mask[vec_pkg::mask_pos(pipe_out.idx)] <= pipe_out.flag;
        end
    end

    // Count register: values above the file length are held at the maximum
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            element_count <= vec_pkg::COUNT_RESET;
        end else if (ctrl_take && issue_cmd.op == vec_pkg::OP_SET_COUNT) begin
            element_count <= (issue_cmd.scalar > W'(vec_pkg::COUNT_MAX)) ? vec_pkg::COUNT_MAX
                : issue_cmd.scalar[CW-1:0];
        end
    end

    // Read-back port for one element, one cycle late
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            read_data <= '0;
        end else begin
            read_data <= elem_file[read_reg][read_idx];
        end
    end

endmodule // vec_chain_unit

// ===== tb/vec_chain_unit_chk.sv
`timescale 1ns/100ps
// Watches the top ports only; every figure is tied to its cause
module vec_chain_unit_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic issue_valid,
    input wire vec_pkg::cmd_s issue_cmd,
    input wire logic arith_busy,
    input wire logic mem_busy,
    input wire logic mem_req_valid,
    input wire vec_pkg::mem_req_s mem_req,
    input wire logic mem_req_ready,
    input wire logic mem_rsp_valid,
    input wire logic [vec_pkg::WORD_W-1:0] mem_rsp_data,
    input wire logic [vec_pkg::MAX_VL-1:0] element_mask,
    input wire logic [vec_pkg::CNT_W-1:0] element_count,
    input wire logic [vec_pkg::REG_W-1:0] read_reg,
    input wire logic [vec_pkg::IDX_W-1:0] read_idx,
    input wire logic [vec_pkg::WORD_W-1:0] read_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////
    // Accepted issues; both slots idle so no destination conflict can refuse them
    logic set_cnt, set_msk, arith_go;
    assign set_cnt = issue_valid && issue_cmd.op == vec_pkg::OP_SET_COUNT && !arith_busy && !mem_busy;
    assign set_msk = issue_valid && issue_cmd.op == vec_pkg::OP_SET_MASK && !arith_busy && !mem_busy;
    assign arith_go = issue_valid && issue_cmd.op <= vec_pkg::OP_CIDX && !arith_busy && !mem_busy
        && element_count != 7'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_count_max: assert property (element_count <= 7'h40)
        else $error("count above maximum");
    a_set_count: assert property (set_cnt |=> element_count == (($past(issue_cmd.scalar) > 64'h40) ? 7'h40
        : $past(issue_cmd.scalar[6:0]))) else $error("count load wrong");
    a_set_mask: assert property (set_msk |=> element_mask == $past(issue_cmd.scalar))
        else $error("mask load wrong");
    a_req_hold: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
        else $error("request dropped before ready");
    a_req_busy: assert property (mem_req_valid |-> mem_busy)
        else $error("request outside memory op");
    a_unit_stream: assert property (arith_go |=> arith_busy[*5] ##[1:100] !arith_busy)
        else $error("unit occupancy wrong");
    a_count_cause: assert property ($changed(element_count) |-> $past(set_cnt))
        else $error("count changed without load");
    a_mask_cause: assert property ($changed(element_mask) |-> arith_busy || $past(set_msk))
        else $error("mask changed without cause");

    // Main scenarios
    c_set_count: cover property (set_cnt);
    c_cidx: cover property (arith_go && issue_cmd.op == vec_pkg::OP_CIDX);
    c_store: cover property (mem_req_valid && mem_req_ready && mem_req.write);
endmodule // vec_chain_unit_chk

// ===== tb/mem_model.sv
`timescale 1ns/100ps
// Memory behind the vector path: stalls one cycle in four, answers loads in order
module mem_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic mem_req_valid,
    input wire vec_pkg::mem_req_s mem_req,
    output logic mem_req_ready,
    output logic mem_rsp_valid,
    output logic [63:0] mem_rsp_data
);
    logic [63:0] pend[$];
    logic [3:0] tick;

    // Address bit 3 set reads as zero, so tests see zero elements
    function automatic logic [63:0] word(input logic [63:0] a);
        word = a[3] ? 64'h0 : a ^ 64'h5a5a_5a5a_5a5a_5a5a;
    endfunction

    // Gaps in both ready and responses make loads pause mid-stream
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 4'h0;
            mem_req_ready <= 1'b0;
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= 64'h0;
            pend.delete();
        end else begin
            tick <= tick + 4'h1;
            mem_req_ready <= tick[1:0] != 2'b11;
            if (pend.size() > 0 && tick[0]) begin
                mem_rsp_valid <= 1'b1;
                mem_rsp_data <= pend.pop_front();
            end else begin
                mem_rsp_valid <= 1'b0;
                mem_rsp_data <= ~mem_rsp_data; // Idle bus alternates between the last word and its inverse
            end
            if (mem_req_valid && mem_req_ready && !mem_req.write)
                pend.push_back(word(mem_req.addr));
        end
    end
endmodule // mem_model

// ===== tb/vec_chain_unit_test.sv
`timescale 1ns/100ps
module vec_chain_unit_test;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic issue_valid = 1'b0;
    vec_pkg::cmd_s issue_cmd = '0;
    vec_pkg::cond_e cd = vec_pkg::COND_ZERO;
    logic arith_busy, mem_busy, mem_req_valid, mem_req_ready, mem_rsp_valid;
    vec_pkg::mem_req_s mem_req, e;
    logic [63:0] mem_rsp_data, read_data, element_mask, sc, bs, st, ad, g, m;
    logic [6:0] element_count;
    logic [2:0] read_reg = 3'h0;
    logic [5:0] read_idx = 6'h0;
    logic [3:0] top_tab [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
    vec_pkg::mem_req_s exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 32'hf5b0_95ae;

    always #25 ref_clk = ~ref_clk;

    vec_chain_unit i_dut (.ref_clk(ref_clk), .rstn(rstn), .issue_valid(issue_valid), .issue_cmd(issue_cmd),
        .arith_busy(arith_busy), .mem_busy(mem_busy), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .element_mask(element_mask), .element_count(element_count), .read_reg(read_reg),
        .read_idx(read_idx), .read_data(read_data));
    mem_model i_mem (.ref_clk(ref_clk), .rstn(rstn), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers; memory pattern kept apart from the model on purpose
    function automatic logic [63:0] word(input logic [63:0] a);
        word = a[3] ? 64'h0 : a ^ 64'h5a5a_5a5a_5a5a_5a5a;
    endfunction
    function automatic logic [63:0] v0w(input int k);
        v0w = word(64'h100 + k * 8);
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] want, input string what);
        cmp_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, want);
        end
    endtask
    // Held until the slot reports busy; set ops take one edge
    task automatic issue(input vec_pkg::op_e op, input logic [2:0] d, a, b, input logic us);
        int n;
        issue_cmd <= '{op, cd, d, a, b, us, sc, bs, st};
        issue_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (!(op >= vec_pkg::OP_SET_COUNT || (op >= vec_pkg::OP_LOAD ? mem_busy : arith_busy)) && n < 200);
        issue_valid <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic idle;
        do begin
            @(posedge ref_clk);
            #1;
        end while (arith_busy || mem_busy || exp_q.size() > 0);
    endtask
    task automatic rd(input logic [2:0] r, input logic [5:0] i, input logic [63:0] want);
        read_reg <= r;
        read_idx <= i;
        @(posedge ref_clk);
        #1;
        chk(read_data, want, "element");
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Request monitor: oldest noted request against each accepted one
    always @(posedge ref_clk) begin
        if (rstn && mem_req_valid && mem_req_ready) begin
            if (exp_q.size() == 0) begin
                chk(64'h1, 64'h0, "unexpected request");
            end else begin
                e = exp_q.pop_front();
                chk(mem_req.write, e.write, "direction");
                chk(mem_req.addr, e.addr, "address");
                if (e.write) chk(mem_req.wdata, e.wdata, "store data");
            end
        end
    end

    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #2_000_000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rstn <= 1'b1;
        chk(element_mask, 64'h0, "mask reset");
        chk(element_count, 64'h40, "count reset");
        sc = 64'h46;
        issue(vec_pkg::OP_SET_COUNT, 0, 0, 0, 0);
        chk(element_count, 64'h40, "count clamp");
        sc = 64'h4;
        issue(vec_pkg::OP_SET_COUNT, 0, 0, 0, 0);
        chk(element_count, 64'h4, "count load");
        $display("count tests done");
        // Stalling strided load with a scalar add chained behind it
        bs = 64'h100;
        st = 64'h8;
        ad = {32'($random(seed)), 32'($random(seed))};
        sc = ad;
        for (int k = 0; k < 4; k++) exp_q.push_back('{1'b0, bs + k * 8, 64'h0});
        issue(vec_pkg::OP_LOAD, 0, 0, 0, 0);
        issue(vec_pkg::OP_ADD, 1, 0, 0, 1);
        idle;
        for (int k = 0; k < 4; k++) begin
            rd(0, k, v0w(k));
            rd(1, k, v0w(k) + ad);
        end
        // Store of the sum with a random base and stride
        bs = {32'h0, 32'($random(seed))};
        st = 64'($random(seed) & 32'hff);
        for (int k = 0; k < 4; k++) exp_q.push_back('{1'b1, bs + k * st, v0w(k) + ad});
        issue(vec_pkg::OP_STORE, 7, 1, 1, 0);
        idle;
        $display("load chain and store done");
        // Gather through index file 0, then scatter the gathered words
        for (int s = 0; s < 2; s++) begin
            g = bs;
            bs = {32'h0, 32'($random(seed))};
            for (int k = 0; k < 4; k++) exp_q.push_back('{s[0], bs + v0w(k), word(g + v0w(k))});
            if (s == 0) issue(vec_pkg::OP_GATHER, 2, 0, 0, 0);
            else issue(vec_pkg::OP_SCATTER, 7, 2, 0, 0);
            idle;
        end
        for (int k = 0; k < 4; k++) rd(2, k, word(g + v0w(k)));
        $display("gather and scatter done");
        // Every test condition, plain and compressed
        for (int o = 0; o < 2; o++) begin
            for (int c = 0; c < 4; c++) begin
                cd = vec_pkg::cond_e'(c);
                issue(o ? vec_pkg::OP_CIDX : vec_pkg::OP_TEST, 3, 0, 0, 0);
                idle;
                chk(element_mask, {top_tab[c], 60'h0}, "mask");
                if (o == 1 && c == 1) begin
                    rd(3, 0, 64'h0);
                    rd(3, 1, 64'h2);
                end
            end
        end
        $display("mask tests done");
        // Random mask then merge of load and sum
        m = {32'($random(seed)), 32'($random(seed))};
        sc = m;
        issue(vec_pkg::OP_SET_MASK, 0, 0, 0, 0);
        chk(element_mask, m, "mask load");
        issue(vec_pkg::OP_MERGE, 4, 0, 1, 0);
        idle;
        for (int k = 0; k < 4; k++) rd(4, k, m[63 - k] ? v0w(k) : v0w(k) + ad);
        // AND then shift by a random scalar
        sc = ad;
        issue(vec_pkg::OP_AND, 5, 0, 0, 1);
        idle;
        sc = 64'($random(seed) & 32'h3f);
        issue(vec_pkg::OP_SHIFT, 6, 5, 0, 1);
        idle;
        for (int k = 0; k < 4; k++) rd(6, k, (v0w(k) & ad) << sc[5:0]);
        $display("merge and logic tests done");
        stop_test;
    end
endmodule // vec_chain_unit_test

bind vec_chain_unit vec_chain_unit_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .issue_valid(issue_valid),
    .issue_cmd(issue_cmd), .arith_busy(arith_busy), .mem_busy(mem_busy), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data), .element_mask(element_mask), .element_count(element_count),
    .read_reg(read_reg), .read_idx(read_idx), .read_data(read_data));
